// [inc/annunciator_pkg.sv]
// constants shared by the alarm sequencer and its input conditioner
// assumes a single 40 MHz system clock and a synchronous active-low reset
package annunciator_pkg;
    localparam int CHANNELS = 4;
    localparam int CLK_HZ = 40_000_000;
    localparam int RESPONSE_TIME_MS = 10;
    localparam int RESPONSE_CYCLES = (CLK_HZ / 1000) * RESPONSE_TIME_MS;
    // debounce at half the response time leaves margin for sync and sequencing
    localparam int DEBOUNCE_TIME_MS = 5;
    localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_TIME_MS;
    localparam int FAST_HALF_MS = 250;
    localparam int FAST_HALF_CYCLES = (CLK_HZ / 1000) * FAST_HALF_MS;
    // register byte addresses
    localparam logic [7:0] CONFIG_OFFSET = 8'h00;
    localparam logic [7:0] ENABLE_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    // per-channel byte lanes in config and status
    localparam int LANE_BITS = 8;
    localparam int CFG_SEQ_POS = 0;
    localparam int CFG_FO_POS = 2;
    localparam int CFG_POL_POS = 3;
    localparam int STS_STATE_POS = 0;
    localparam int STS_FO_POS = 2;
    localparam int STS_ABN_POS = 3;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam logic [3:0] ENABLE_RESET = 4'hf;
    // sequence selection codes
    localparam logic [1:0] SEQ_AUTO = 2'h0;
    localparam logic [1:0] SEQ_MANUAL = 2'h1;
    localparam logic [1:0] SEQ_RINGBACK = 2'h2;
    typedef enum logic [1:0] {
        ST_NORMAL,
        ST_ALERT,
        ST_ACKED,
        ST_RINGBACK
    } chan_state_t;
endpackage : annunciator_pkg

// [logic/input_conditioner.sv]
// two-flop synchroniser and debounce filter for a group of slow inputs
// assumes inputs are static far longer than the debounce window
`timescale 1ns/1ps
module input_conditioner #(
    parameter int WIDTH = 8,
    parameter int CYCLES = 200000
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [WIDTH-1:0] raw_in,
    output logic [WIDTH-1:0] clean_out
);
    localparam logic [23:0] LIMIT = 24'(CYCLES - 1);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= raw_in;
            sync_reg <= meta_reg;
        end
    end
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic [23:0] cnt_reg;
            logic stable_reg;
            wire differs = sync_reg[i] != stable_reg;
            wire done = cnt_reg == LIMIT;
            always_ff @(posedge clk_in)
            begin
                if (!reset_n_in)
                begin
                    cnt_reg <= '0;
                    stable_reg <= 1'b0;
                end
                else
                begin
                    cnt_reg <= (differs && !done) ? cnt_reg + 24'h1 : 24'h0;
                    stable_reg <= (differs && done) ? sync_reg[i] : stable_reg;
                end
            end
            assign clean_out[i] = stable_reg;
        end
    endgenerate
endmodule : input_conditioner

// [logic/annunciator_alarm_sequencer.sv]
// four-channel alarm annunciator sequencer with an AHB-Lite register slave
// assumes contacts and pushbuttons are slow, bounce, and are not yet synchronised
// Operation
// - abnormal input latches alarm until acknowledged
// - manual: acknowledge silences horn, lamp steady
// - manual: cleared acked alarm waits for reset
// - automatic: acked alarm clears on return
// - ringback: return enters ringback, slow flash, horn
// - ringback: acknowledge silences horn, steady lamp
// - ringback holds until reset pressed or the input goes abnormal again
// - separate alarm and ringback horn outputs
// - first-out channel flashes with distinct pattern
// - first-out reset makes first indication ordinary
// - acknowledge, reset, test pushbuttons accepted
// - per-channel normally open or closed polarity
// - one to four independent channels
// - reflash pulses on every new alarm
// - sequence and options held in registers
// - input change registered within 10 ms
// - fast, slow, steady, intermittent lamp patterns
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module annunciator_alarm_sequencer #(
    parameter int DEBOUNCE_CYC = annunciator_pkg::DEBOUNCE_CYCLES,
    parameter int FAST_HALF_CYC = annunciator_pkg::FAST_HALF_CYCLES
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    input wire logic [annunciator_pkg::CHANNELS-1:0] field_in,
    input wire logic ack_pb_in,
    input wire logic reset_pb_in,
    input wire logic first_out_reset_pb_in,
    input wire logic test_pb_in,
    output logic [annunciator_pkg::CHANNELS-1:0] lamp_out,
    output logic alarm_horn_out,
    output logic ringback_horn_out,
    output logic reflash_out
);
    import annunciator_pkg::*;

    localparam logic [23:0] FAST_LIMIT = 24'(FAST_HALF_CYC - 1);

    // bus slave: zero wait state, always OKAY
    logic [31:0] config_reg;
    logic [3:0] enable_reg;
    logic [31:0] status_word;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    wire take = hsel_in && hready_in && htrans_in[1];
    wire [7:0] addr_lo = haddr_in[7:0];
    wire addr_in_map = haddr_in[31:8] == 24'h0;
    wire [31:0] rd_value = !addr_in_map ? 32'h0 :
        (addr_lo == CONFIG_OFFSET) ? config_reg :
        (addr_lo == ENABLE_OFFSET) ? {28'h0, enable_reg} :
        (addr_lo == STATUS_OFFSET) ? status_word : 32'h0;
    wire wr_cfg = wr_pend_reg && wr_addr_reg == CONFIG_OFFSET;
    wire wr_en = wr_pend_reg && wr_addr_reg == ENABLE_OFFSET;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h0;
            hrdata_out <= 32'h0;
        end
        else
        begin
            wr_pend_reg <= take && hwrite_in && addr_in_map;
            wr_addr_reg <= addr_lo;
            hrdata_out <= (take && !hwrite_in) ? rd_value : 32'h0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            config_reg <= CONFIG_RESET;
            enable_reg <= ENABLE_RESET;
        end
        else
        begin
            config_reg <= wr_cfg ? hwdata_in : config_reg;
            enable_reg <= wr_en ? hwdata_in[3:0] : enable_reg;
        end
    end

    // conditioned inputs: four contacts then four pushbuttons
    logic [7:0] clean;
    input_conditioner #(
        .WIDTH(8),
        .CYCLES(DEBOUNCE_CYC)
    ) u_cond (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .raw_in({test_pb_in, first_out_reset_pb_in, reset_pb_in, ack_pb_in, field_in}),
        .clean_out(clean)
    );

    logic [3:0] pb_prev_reg;
    wire [3:0] pb_level = clean[7:4];
    wire [3:0] pb_edge = pb_level & ~pb_prev_reg;
    wire ack_edge = pb_edge[0];
    wire reset_edge = pb_edge[1];
    wire fo_reset_edge = pb_edge[2];
    wire test_level = pb_level[3];

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
            pb_prev_reg <= 4'h0;
        else
            pb_prev_reg <= pb_level;
    end

    // shared timebase keeps every flashing lamp in step
    logic [23:0] tb_cnt_reg;
    logic [2:0] phase_reg;
    wire tb_tick = tb_cnt_reg == FAST_LIMIT;
    wire fast_flash = phase_reg[0];
    wire slow_flash = phase_reg[2];
    wire inter_flash = phase_reg[0] & phase_reg[2];

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            tb_cnt_reg <= 24'h0;
            phase_reg <= 3'h0;
        end
        else
        begin
            tb_cnt_reg <= tb_tick ? 24'h0 : tb_cnt_reg + 24'h1;
            phase_reg <= tb_tick ? phase_reg + 3'h1 : phase_reg;
        end
    end

    function automatic logic [1:0] state_code(input chan_state_t s);
        case (s)
            ST_NORMAL: state_code = 2'h0;
            ST_ALERT: state_code = 2'h1;
            ST_ACKED: state_code = 2'h2;
            default: state_code = 2'h3;
        endcase
    endfunction : state_code

    chan_state_t state_reg [CHANNELS];
    chan_state_t state_next [CHANNELS];
    logic [CHANNELS-1:0] abn;
    logic [CHANNELS-1:0] fo_en;
    logic [CHANNELS-1:0] enter;
    logic [CHANNELS-1:0] in_alarm;
    logic [CHANNELS-1:0] in_alert;
    logic [CHANNELS-1:0] in_ringback;
    logic [CHANNELS-1:0] pattern;
    logic [CHANNELS-1:0] fo_flag_reg;

    // first-out group: lowest index wins a simultaneous arrival
    wire [CHANNELS-1:0] fo_cand = enter & fo_en;
    wire group_busy = |(in_alarm & fo_en) || |fo_flag_reg;
    wire [CHANNELS-1:0] fo_pick = fo_cand & ~(fo_cand - 4'h1);
    wire [CHANNELS-1:0] fo_set = group_busy ? 4'h0 : fo_pick;
    wire [CHANNELS-1:0] fo_clr = {CHANNELS{fo_reset_edge}} | ~in_alarm;

    genvar i;
    generate
        for (i = 0; i < CHANNELS; i++)
        begin : g_chan
            wire [1:0] seq = config_reg[i*LANE_BITS+CFG_SEQ_POS +: 2];
            wire pol_nc = config_reg[i*LANE_BITS+CFG_POL_POS];
            wire en = enable_reg[i];
            wire is_auto = seq == SEQ_AUTO;
            wire is_rb = seq == SEQ_RINGBACK;
            // reserved code falls back to manual reset, the safest hold-on behaviour
            wire is_man = !is_auto && !is_rb;
            assign abn[i] = en && (clean[i] ^ pol_nc);
            assign fo_en[i] = config_reg[i*LANE_BITS+CFG_FO_POS];
            assign in_alarm[i] = state_reg[i] != ST_NORMAL;
            assign in_alert[i] = state_reg[i] == ST_ALERT;
            assign in_ringback[i] = state_reg[i] == ST_RINGBACK;
            assign enter[i] = state_reg[i] != ST_ALERT && state_next[i] == ST_ALERT;

            always_comb
            begin
                state_next[i] = state_reg[i];
                case (state_reg[i])
                    ST_NORMAL:
                        if (abn[i])
                            state_next[i] = ST_ALERT;
                    ST_ALERT:
                        if (ack_edge)
                        begin
                            if (abn[i] || is_man)
                                state_next[i] = ST_ACKED;
                            else if (is_rb)
                                state_next[i] = ST_RINGBACK;
                            else
                                state_next[i] = ST_NORMAL;
                        end
                    ST_ACKED:
                        if (!abn[i])
                        begin
                            if (is_auto)
                                state_next[i] = ST_NORMAL;
                            else if (is_rb)
                                state_next[i] = ST_RINGBACK;
                            else if (reset_edge)
                                state_next[i] = ST_NORMAL;
                        end
                    default:
                        if (abn[i])
                            state_next[i] = ST_ALERT;
                        else if (reset_edge)
                            state_next[i] = ST_NORMAL;
                endcase
                if (!en)
                    state_next[i] = ST_NORMAL;
            end

            always_comb
            begin
                case (state_reg[i])
                    ST_ALERT: pattern[i] = fo_flag_reg[i] ? inter_flash : fast_flash;
                    ST_ACKED: pattern[i] = 1'b1;
                    ST_RINGBACK: pattern[i] = slow_flash;
                    default: pattern[i] = 1'b0;
                endcase
            end

            always_ff @(posedge clk_in)
            begin
                if (!reset_n_in)
                    state_reg[i] <= ST_NORMAL;
                else
                    state_reg[i] <= state_next[i];
            end

            assign status_word[i*LANE_BITS +: LANE_BITS] =
                {4'h0, abn[i], fo_flag_reg[i], state_code(state_reg[i])};

            a_lock_in: assert property (@(posedge clk_in) disable iff (!reset_n_in)
                state_reg[i] == ST_NORMAL && abn[i] |=> state_reg[i] == ST_ALERT)
                else $error("alarm not latched");
            a_alert_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
                in_alert[i] && !ack_edge && en |=> in_alert[i])
                else $error("alert left without acknowledge");
            // the horn is registered, so it goes quiet one cycle after the state moves;
            // a fresh arrival in the acknowledge cycle or a held test may keep it sounding
            a_manual_ack: assert property (@(posedge clk_in) disable iff (!reset_n_in)
                in_alert[i] && ack_edge && is_man && en |=> state_reg[i] == ST_ACKED
                && pattern[i]
                ##1 (!alarm_horn_out || $past(|enter, 2) || $past(test_level)))
                else $error("manual acknowledge not steady");
            a_manual_wait: assert property (@(posedge clk_in) disable iff (!reset_n_in)
                state_reg[i] == ST_ACKED && is_man && !reset_edge && en
                |=> state_reg[i] == ST_ACKED)
                else $error("manual alarm cleared without reset");
            a_auto_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
                state_reg[i] == ST_ACKED && is_auto && !abn[i] |=> !in_alarm[i])
                else $error("automatic alarm did not clear");
            a_ringback_entry: assert property (@(posedge clk_in) disable iff (!reset_n_in)
                state_reg[i] == ST_ACKED && is_rb && !abn[i] && en
                |=> in_ringback[i] ##1 ringback_horn_out)
                else $error("ringback not entered");
            a_ringback_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
                in_ringback[i] && !abn[i] && !reset_edge && en |=> in_ringback[i])
                else $error("ringback left without reset");
            a_ringback_ack: assert property (@(posedge clk_in) disable iff (!reset_n_in)
                in_alert[i] && ack_edge && is_rb && abn[i] && en
                |=> state_reg[i] == ST_ACKED && pattern[i])
                else $error("ringback acknowledge not steady");
            a_disable_off: assert property (@(posedge clk_in) disable iff (!reset_n_in)
                !en |=> state_reg[i] == ST_NORMAL)
                else $error("disabled channel kept state");
            a_reflash_new: assert property (@(posedge clk_in) disable iff (!reset_n_in)
                !in_alert[i] ##1 in_alert[i] |-> reflash_out)
                else $error("new alarm without reflash");
        end
    endgenerate

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
            fo_flag_reg <= 4'h0;
        else
            fo_flag_reg <= fo_set | (fo_flag_reg & ~fo_clr);
    end

    // outputs from flip-flops; test overrides display without touching state
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            lamp_out <= 4'h0;
            alarm_horn_out <= 1'b0;
            ringback_horn_out <= 1'b0;
            reflash_out <= 1'b0;
        end
        else
        begin
            lamp_out <= test_level ? enable_reg : pattern;
            alarm_horn_out <= test_level || |in_alert;
            ringback_horn_out <= test_level || |in_ringback;
            reflash_out <= |enter;
        end
    end

    a_reflash_pulse: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        |enter |=> reflash_out ##1 (reflash_out == $past(|enter)))
        else $error("reflash missing");
    a_test_display: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        test_level |=> lamp_out == $past(enable_reg) && alarm_horn_out && ringback_horn_out)
        else $error("test did not light and sound");
    a_horn_split: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !test_level && !(|in_ringback) && |in_alert |=> alarm_horn_out && !ringback_horn_out)
        else $error("horns not independent");
    a_first_out_one: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $onehot0(fo_flag_reg))
        else $error("more than one first-out channel");
    a_fo_reset: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        fo_reset_edge && !(|fo_set) |=> fo_flag_reg == 4'h0)
        else $error("first-out flag survived reset");

    c_ringback: cover property (@(posedge clk_in) disable iff (!reset_n_in) |in_ringback);
    c_first_out: cover property (@(posedge clk_in) disable iff (!reset_n_in) |fo_flag_reg);
    c_reflash_busy: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        reflash_out && $countones(in_alarm) > 1);
    c_test_held: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        test_level && |in_alarm);
    c_channel_off: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        !(&enable_reg) && |lamp_out);
endmodule : annunciator_alarm_sequencer

// [dv/field_panel_model.sv]
// field contacts and operator pushbuttons standing in front of the sequencer
// assumes the bench sets contact and button levels just after a rising edge
`timescale 1ns/1ps
module field_panel_model (
    input wire logic clk_in,
    input wire logic [3:0] contact_in,
    input wire logic [3:0] button_in,
    output logic [3:0] field_out,
    output logic ack_out,
    output logic reset_out,
    output logic first_out_reset_out,
    output logic test_out
);
    logic [7:0] level_reg = 8'h00;
    logic [7:0] bounce_reg = 8'h00;
    logic [7:0] wire_reg = 8'h00;
    // every change chatters back to the old level for one cycle, like a real contact
    always @(posedge clk_in)
    begin
        level_reg <= {button_in, contact_in};
        bounce_reg <= {button_in, contact_in} ^ level_reg;
        wire_reg <= {button_in, contact_in} ^ bounce_reg;
    end
    assign field_out = wire_reg[3:0];
    assign ack_out = wire_reg[4];
    assign reset_out = wire_reg[5];
    assign first_out_reset_out = wire_reg[6];
    assign test_out = wire_reg[7];
endmodule : field_panel_model

// [dv/testbench.sv]
// self-checking bench: AHB-Lite register access plus contact and pushbutton sequences
// assumes a single slave whose hreadyout closes the hready loop
`timescale 1ns/1ps
module testbench;
    import annunciator_pkg::*;
    localparam int LIMIT = 20000;
    localparam logic [31:0] A_CFG = {24'h000000, CONFIG_OFFSET};
    localparam logic [31:0] A_EN = {24'h000000, ENABLE_OFFSET};
    localparam logic [31:0] A_STS = {24'h000000, STATUS_OFFSET};
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire logic hreadyout_out;
    wire logic hresp_out;
    wire logic [31:0] hrdata_out;
    // contact 3 starts closed: it is the normally-closed channel
    logic [3:0] contact = 4'h8;
    logic [3:0] button = 4'h0;
    wire logic [3:0] field;
    wire logic ack_pb, reset_pb, fo_pb, test_pb;
    wire logic [3:0] lamp_out;
    wire logic alarm_horn_out, ringback_horn_out, reflash_out;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;
    int reflash_cnt = 0;
    int rf0;
    logic [31:0] r;

    always #12.5 clk_in = ~clk_in;

    field_panel_model panel_u (.clk_in(clk_in), .contact_in(contact), .button_in(button),
        .field_out(field), .ack_out(ack_pb), .reset_out(reset_pb),
        .first_out_reset_out(fo_pb), .test_out(test_pb));

    // short counts keep the run brief; all expectations follow from 4 and 4
    annunciator_alarm_sequencer #(.DEBOUNCE_CYC(4), .FAST_HALF_CYC(4)) dut_u (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hreadyout_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
        .hrdata_out(hrdata_out), .field_in(field), .ack_pb_in(ack_pb),
        .reset_pb_in(reset_pb), .first_out_reset_pb_in(fo_pb), .test_pb_in(test_pb),
        .lamp_out(lamp_out), .alarm_horn_out(alarm_horn_out),
        .ringback_horn_out(ringback_horn_out), .reflash_out(reflash_out));

    task automatic end_of_test();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    always @(posedge clk_in)
    begin
        cycles++;
        if (reflash_out === 1'b1)
            reflash_cnt++;
        if (cycles == LIMIT)
        begin
            fails++;
            $display("[ERR] t=%0t run did not finish in time", $time);
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask : cyc

    // a transfer waits for hready at both phase ends; the timeout cuts a hang
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge clk_in);
        while (hreadyout_out !== 1'b1) @(posedge clk_in);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk_in);
        while (hreadyout_out !== 1'b1) @(posedge clk_in);
        rd = hrdata_out;
        check({31'h0, hresp_out}, 32'h0);
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] rd;
        bus(1'b1, a, d, rd);
    endtask : wr

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        bus(1'b0, a, 32'h0, rd);
        check(rd, exp);
    endtask : rd_chk

    task automatic st_chk(input int ch, input logic [1:0] exp);
        logic [31:0] rd;
        bus(1'b0, A_STS, 32'h0, rd);
        check({30'h0, rd[8*ch +: 2]}, {30'h0, exp});
    endtask : st_chk

    // 64 cycles span whole periods of every flash pattern at these counts
    task automatic lamp_cnt(input int ch, input int exp);
        int n;
        n = 0;
        repeat (64)
        begin
            @(posedge clk_in);
            if (lamp_out[ch] === 1'b1)
                n++;
        end
        check(n, exp);
    endtask : lamp_cnt

    task automatic set_contact(input int ch, input logic v);
        contact[ch] <= v;
        cyc(14);
    endtask : set_contact

    task automatic press(input int b);
        button[b] <= 1'b1;
        cyc(12);
        button[b] <= 1'b0;
        cyc(14);
    endtask : press

    initial
    begin
        cyc(16);
        reset_n_in <= 1'b1;
        cyc(20);
        rd_chk(A_CFG, CONFIG_RESET);
        rd_chk(A_EN, {28'h0, ENABLE_RESET});
        wr(32'h0000_0100, 32'hffff_ffff);
        rd_chk(32'h0000_0100, 32'h0);
        // lanes: 0 automatic, 1 manual, 2 ringback, 3 automatic normally closed
        wr(A_CFG, 32'h0802_0100);
        rd_chk(A_CFG, 32'h0802_0100);
        // automatic channel 0: a brief excursion stays latched
        rf0 = reflash_cnt;
        set_contact(0, 1'b1);
        st_chk(0, ST_ALERT);
        check(reflash_cnt - rf0, 1);
        check({31'h0, alarm_horn_out}, 32'h1);
        set_contact(0, 1'b0);
        st_chk(0, ST_ALERT);
        lamp_cnt(0, 32);
        press(0);
        st_chk(0, ST_NORMAL);
        set_contact(0, 1'b1);
        press(0);
        st_chk(0, ST_ACKED);
        set_contact(0, 1'b0);
        st_chk(0, ST_NORMAL);
        // manual channel 1, with a lamp test while acknowledged
        set_contact(1, 1'b1);
        press(0);
        st_chk(1, ST_ACKED);
        check({31'h0, alarm_horn_out}, 32'h0);
        lamp_cnt(1, 64);
        button[3] <= 1'b1;
        cyc(14);
        check({28'h0, lamp_out}, 32'hf);
        check({30'h0, alarm_horn_out, ringback_horn_out}, 32'h3);
        button[3] <= 1'b0;
        cyc(14);
        st_chk(1, ST_ACKED);
        set_contact(1, 1'b0);
        st_chk(1, ST_ACKED);
        press(1);
        st_chk(1, ST_NORMAL);
        // ringback channel 2
        set_contact(2, 1'b1);
        press(0);
        st_chk(2, ST_ACKED);
        check({31'h0, alarm_horn_out}, 32'h0);
        lamp_cnt(2, 64);
        set_contact(2, 1'b0);
        st_chk(2, ST_RINGBACK);
        check({30'h0, alarm_horn_out, ringback_horn_out}, 32'h1);
        lamp_cnt(2, 32);
        st_chk(2, ST_RINGBACK);
        press(1);
        st_chk(2, ST_NORMAL);
        check({31'h0, ringback_horn_out}, 32'h0);
        // normally-closed channel 3 alarms when its contact opens
        set_contact(3, 1'b0);
        st_chk(3, ST_ALERT);
        wr(A_EN, 32'h7);
        cyc(4);
        st_chk(3, ST_NORMAL);
        check({31'h0, lamp_out[3]}, 32'h0);
        wr(A_EN, 32'hf);
        set_contact(3, 1'b1);
        press(0);
        st_chk(3, ST_NORMAL);
        // first-out group of channels 0 and 1
        wr(A_CFG, 32'h0800_0404);
        rf0 = reflash_cnt;
        set_contact(0, 1'b1);
        set_contact(1, 1'b1);
        check(reflash_cnt - rf0, 2);
        bus(1'b0, A_STS, 32'h0, r);
        check({30'h0, r[10], r[2]}, 32'h1);
        lamp_cnt(0, 16);
        lamp_cnt(1, 32);
        press(2);
        bus(1'b0, A_STS, 32'h0, r);
        check({31'h0, r[2]}, 32'h0);
        lamp_cnt(0, 32);
        press(0);
        contact[0] <= 1'b0;
        set_contact(1, 1'b0);
        rd_chk(A_STS, 32'h0);
        end_of_test();
    end
endmodule : testbench
